// ==== asu_defs.vh ====
// Register map, field positions, encodings and counts of the serial channel
`ifndef ASU_DEFS_VH
`define ASU_DEFS_VH
`define ASU_ADDR_TXBUF   8'h00
`define ASU_ADDR_RXBUF   8'h04
`define ASU_ADDR_BAUD    8'h08
`define ASU_ADDR_MODE    8'h0C
`define ASU_ADDR_CTRL1   8'h10
`define ASU_ADDR_CTRL2   8'h14
`define ASU_ADDR_SMR1    8'h18
`define ASU_ADDR_SMR2    8'h1C
`define ASU_ADDR_SMR3    8'h20
`define ASU_ADDR_SMR4    8'h24
`define ASU_ADDR_COMMON  8'h28
`define ASU_SMD_7BIT     3'h4
`define ASU_SMD_8BIT     3'h5
`define ASU_SMD_9BIT     3'h6
`define ASU_MODE_EXT     3
`define ASU_MODE_STOP    4
`define ASU_MODE_ODD     5
`define ASU_MODE_PEN     6
`define ASU_MODE_POL     7
`define ASU_C1_PRE       0
`define ASU_C1_FPS       2
`define ASU_C1_SHIFT_REG_EMPTY     3
`define ASU_C1_FDIS      4
`define ASU_C1_OD        5
`define ASU_C1_ORDER     7
`define ASU_C2_TXEN      0
`define ASU_C2_TBE       1
`define ASU_C2_RXEN      2
`define ASU_C2_RXC       3
`define ASU_C2_IRS       4
`define ASU_C2_INV       6
`define ASU_COM_ALT      6
`define ASU_RB_OVR       12
`define ASU_RB_FRM       13
`define ASU_RB_PAR       14
`define ASU_RB_SUM       15
`define ASU_RST_REG      8'h00
`define ASU_OVS_LAST     4'hF
`define ASU_OVS_MID      4'h7
`define ASU_PRE_DIV1     5'h00
`define ASU_PRE_DIV2     5'h01
`define ASU_PRE_DIV8     5'h07
`define ASU_PRE_DIV32    5'h1F
`endif

// ==== asu_tx.v ====
// Transmit shifter: start, data, optional parity and stop bits
`include "asu_defs.vh"
`default_nettype none
module asu_tx (
  input  wire       pclk,     // System clock
  input  wire       presetn,  // Async reset, active low
  input  wire       tick,     // 16x bit-rate enable
  input  wire       start,    // Load frame, one cycle
  input  wire [8:0] data,     // Masked, ordered data
  input  wire [3:0] nbits,    // Character length
  input  wire       par_en,   // Parity on
  input  wire       par_odd,  // Odd parity
  input  wire       two_stop, // Two stop bits
  output reg        line,     // Serial level, idle high
  output reg        busy,     // Shift register in use
  output reg        done      // Last stop bit sent
);
  reg  [11:0] shreg;
  reg  [11:0] next_frame;
  reg  [3:0]  sub;
  reg  [3:0]  rem;
  wire        par_bit;
  integer     i;

  assign par_bit = (^data) ^ par_odd;

  always @* begin
    next_frame = 12'hFFF;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < nbits)
        next_frame[i] = data[i];
    end
    if (par_en)
      next_frame[nbits] = par_bit;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line  <= 1'b1;
      busy  <= 1'b0;
      done  <= 1'b0;
      shreg <= 12'hFFF;
      sub   <= 4'h0;
      rem   <= 4'h0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        line  <= 1'b0;
        shreg <= next_frame;
        sub   <= 4'h0;
        rem   <= nbits + {3'h0, par_en} + {3'h0, two_stop} + 4'h1;
      end else if (busy && tick) begin
        sub <= sub + 4'h1;
        if (sub == `ASU_OVS_LAST) begin
          if (rem == 4'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
            line <= 1'b1;
          end else begin
            line  <= shreg[0];
            shreg <= {1'b1, shreg[11:1]};
            rem   <= rem - 4'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== asu_rx.v ====
// Receive sampler: start detect, mid-bit sampling, parity and stop checks
`include "asu_defs.vh"
`default_nettype none
module asu_rx (
  input  wire       pclk,     // System clock
  input  wire       presetn,  // Async reset, active low
  input  wire       tick,     // 16x bit-rate enable
  input  wire       enable,   // Reception allowed
  input  wire       line,     // Polarity-corrected input
  input  wire [3:0] nbits,    // Character length
  input  wire       par_en,   // Parity on
  input  wire       par_odd,  // Odd parity
  input  wire       two_stop, // Two stop bits
  output reg  [8:0] data,     // Received bits, LSB first
  output reg        perr,     // Parity mismatch
  output reg        ferr,     // Stop bit missing
  output reg        done      // Character complete
);
  reg        busy;
  reg        prev;
  reg        pacc;
  reg  [3:0] sub;
  reg  [3:0] idx;
  wire [3:0] last;
  wire [3:0] pos;

  assign last = nbits + {3'h0, par_en} + 4'h1 + {3'h0, two_stop};
  assign pos  = idx - 4'h1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      prev <= 1'b1;
      pacc <= 1'b0;
      sub  <= 4'h0;
      idx  <= 4'h0;
      data <= 9'h000;
      perr <= 1'b0;
      ferr <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        if (!busy) begin
          prev <= line;
          if (enable && prev && !line) begin
            busy <= 1'b1;
            sub  <= 4'h1;
            idx  <= 4'h0;
            pacc <= 1'b0;
            data <= 9'h000;
            perr <= 1'b0;
            ferr <= 1'b0;
          end
        end else begin
          sub <= sub + 4'h1;
          if (sub == `ASU_OVS_MID) begin
            idx <= idx + 4'h1;
            if (idx == 4'h0) begin
              if (line) begin
                busy <= 1'b0;
                prev <= 1'b1;
              end
            end else if (pos < nbits) begin
              data[pos] <= line;
              pacc      <= pacc ^ line;
            end else if (par_en && pos == nbits) begin
              perr <= pacc ^ line ^ par_odd;
            end else if (!line) begin
              ferr <= 1'b1;
            end
            if (idx == last) begin
              busy <= 1'b0;
              done <= 1'b1;
              prev <= line;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== asu_top.v ====
// Asynchronous serial channel with APB registers, baud generator and flow pins
`include "asu_defs.vh"
`default_nettype none
module asu_top #(
  parameter CHAN = 0  // Channel number, 0 to 2
) (
  input  wire        pclk,           // System clock
  input  wire        presetn,        // Async reset, active low
  input  wire        psel,           // APB select
  input  wire        penable,        // APB access phase
  input  wire        pwrite,         // APB write
  input  wire [7:0]  paddr,          // APB byte address
  input  wire [31:0] pwdata,         // APB write data
  output reg  [31:0] prdata,         // APB read data
  output reg         pready,         // APB ready
  output reg         pslverr,        // APB error, unmapped
  input  wire        serial_in_pin,  // Receive pin level
  output reg         serial_out_pin, // Transmit pin level
  output reg         serial_out_oe,  // Transmit pin driven
  input  wire        ext_clock_pin,  // External transfer clock
  input  wire        flow_pin_in,    // Own CTS/RTS pin level
  output reg         flow_pin_out,   // RTS level
  output reg         flow_pin_oe,    // RTS pin driven
  input  wire        cts_alt_pin,    // Shared CTS pin level
  output reg         tx_irq,         // Transmit event pulse
  output reg         rx_irq          // Receive event pulse
);
  reg  [8:0]  tx_buffer;
  reg  [15:0] rx_buffer;
  reg  [7:0]  baud_divider;
  reg  [7:0]  serial_mode_reg;
  reg  [7:0]  serial_ctrl_first;
  reg  [7:0]  serial_ctrl_second;
  reg  [7:0]  special_mode_one;
  reg  [7:0]  special_mode_two;
  reg  [7:0]  special_mode_three;
  reg  [7:0]  special_mode_four;
  reg  [7:0]  serial_common_ctrl;
  reg         tx_buffer_empty;
  reg         rx_complete;
  reg  [4:0]  pre_cnt;
  reg         ext_prev;
  reg  [7:0]  brg_cnt;
  reg         tick16;
  reg  [4:0]  pre_last;
  reg  [3:0]  nbits;
  reg  [8:0]  tx_word;
  reg  [8:0]  rx_word;
  reg  [31:0] next_prdata;
  reg         next_slverr;

  wire [2:0]  serial_mode_field;
  wire        uart_on;
  wire        clock_source_ext;
  wire        stop_count;
  wire        parity_odd_even;
  wire        parity_enable;
  wire        pin_polarity_invert;
  wire [1:0]  brg_prescale_select;
  wire        flow_pin_select;
  wire        flow_ctrl_disable;
  wire        open_drain_select;
  wire        bit_order_select;
  wire        tx_allow;
  wire        rx_allow;
  wire        data_logic_invert;
  wire        cts_alt_pin_select;
  wire        tx_irq_source;
  wire        flow_borrowed;
  wire        flow_on;
  wire        cts_level;
  wire        cts_ok;
  wire        msb_first;
  wire [8:0]  len_mask;
  wire        pre_en;
  wire        src_en;
  wire        tx_start;
  wire        tx_line;
  wire        tx_busy;
  wire        tx_done;
  wire        pin_level;
  wire [8:0]  rx_data;
  wire        rx_perr;
  wire        rx_ferr;
  wire        rx_done;
  wire        wr_en;
  wire        rd_rxbuf;
  wire        wr_txbuf;
  wire        new_ovr;

  assign serial_mode_field   = serial_mode_reg[2:0];
  assign clock_source_ext    = serial_mode_reg[`ASU_MODE_EXT];
  assign stop_count          = serial_mode_reg[`ASU_MODE_STOP];
  assign parity_odd_even     = serial_mode_reg[`ASU_MODE_ODD];
  assign parity_enable       = serial_mode_reg[`ASU_MODE_PEN];
  assign pin_polarity_invert = serial_mode_reg[`ASU_MODE_POL];
  assign brg_prescale_select = serial_ctrl_first[`ASU_C1_PRE+1:`ASU_C1_PRE];
  assign flow_pin_select     = serial_ctrl_first[`ASU_C1_FPS];
  assign flow_ctrl_disable   = serial_ctrl_first[`ASU_C1_FDIS];
  assign open_drain_select   = serial_ctrl_first[`ASU_C1_OD];
  assign bit_order_select    = serial_ctrl_first[`ASU_C1_ORDER];
  assign tx_allow            = serial_ctrl_second[`ASU_C2_TXEN];
  assign rx_allow            = serial_ctrl_second[`ASU_C2_RXEN];
  assign data_logic_invert   = serial_ctrl_second[`ASU_C2_INV];
  assign cts_alt_pin_select  = serial_common_ctrl[`ASU_COM_ALT];

  always @* begin
    case (serial_mode_field)
      `ASU_SMD_7BIT: nbits = 4'd7;
      `ASU_SMD_8BIT: nbits = 4'd8;
      `ASU_SMD_9BIT: nbits = 4'd9;
      default:       nbits = 4'd0;
    endcase
  end
  assign uart_on = (nbits != 4'd0);

  assign len_mask  = (nbits == 4'd9) ? 9'h1FF : (nbits == 4'd8) ? 9'h0FF : 9'h07F;
  assign msb_first = bit_order_select && (nbits == 4'd8);

  assign tx_irq_source = (CHAN == 2) ? serial_ctrl_second[`ASU_C2_IRS] : serial_common_ctrl[CHAN % 2];

  assign flow_borrowed = (CHAN == 1) && cts_alt_pin_select;
  assign flow_on   = !flow_ctrl_disable && !flow_borrowed;
  assign cts_level = ((CHAN == 0) && cts_alt_pin_select) ? cts_alt_pin : flow_pin_in;
  assign cts_ok    = !flow_on || ((CHAN == 0) && cts_alt_pin_select) ? (!flow_on || !cts_level)
                   : (flow_pin_select || !cts_level);

  always @* begin
    case (brg_prescale_select)
      2'h0:    pre_last = `ASU_PRE_DIV1;
      2'h1:    pre_last = `ASU_PRE_DIV2;
      2'h2:    pre_last = `ASU_PRE_DIV8;
      default: pre_last = `ASU_PRE_DIV32;
    endcase
  end
  assign pre_en = (pre_cnt >= pre_last);
  assign src_en = clock_source_ext ? (ext_clock_pin && !ext_prev) : pre_en;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt  <= 5'h00;
      ext_prev <= 1'b0;
      brg_cnt  <= 8'h00;
      tick16   <= 1'b0;
    end else begin
      ext_prev <= ext_clock_pin;
      pre_cnt  <= pre_en ? 5'h00 : pre_cnt + 5'h01;
      tick16   <= 1'b0;
      if (src_en) begin
        if (brg_cnt == 8'h00) begin
          brg_cnt <= baud_divider;
          tick16  <= 1'b1;
        end else begin
          brg_cnt <= brg_cnt - 8'h01;
        end
      end
    end
  end

  assign tx_start = uart_on && tx_allow && !tx_buffer_empty && cts_ok && !tx_busy;

  always @* begin
    tx_word = tx_buffer & len_mask;
    if (data_logic_invert)
      tx_word = ~tx_buffer & len_mask;
    if (msb_first)
      tx_word = {1'b0, tx_word[0], tx_word[1], tx_word[2], tx_word[3],
                 tx_word[4], tx_word[5], tx_word[6], tx_word[7]};
  end

  asu_tx u_tx (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick16),
    .start    (tx_start),
    .data     (tx_word),
    .nbits    (nbits),
    .par_en   (parity_enable),
    .par_odd  (parity_odd_even),
    .two_stop (stop_count),
    .line     (tx_line),
    .busy     (tx_busy),
    .done     (tx_done)
  );

  assign pin_level = tx_line ^ pin_polarity_invert;

  asu_rx u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick16),
    .enable   (uart_on && rx_allow),
    .line     (serial_in_pin ^ pin_polarity_invert),
    .nbits    (nbits),
    .par_en   (parity_enable),
    .par_odd  (parity_odd_even),
    .two_stop (stop_count),
    .data     (rx_data),
    .perr     (rx_perr),
    .ferr     (rx_ferr),
    .done     (rx_done)
  );

  always @* begin
    rx_word = rx_data & len_mask;
    if (msb_first)
      rx_word = {1'b0, rx_word[0], rx_word[1], rx_word[2], rx_word[3],
                 rx_word[4], rx_word[5], rx_word[6], rx_word[7]};
  end

  assign wr_en    = psel && penable && pready && pwrite;
  assign wr_txbuf = wr_en && (paddr == `ASU_ADDR_TXBUF);
  assign rd_rxbuf = psel && penable && pready && !pwrite && (paddr == `ASU_ADDR_RXBUF);
  assign new_ovr  = rx_complete && !rd_rxbuf;

  // Pin drivers, RTS low while ready to take a character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
      flow_pin_out   <= 1'b1;
      flow_pin_oe    <= 1'b0;
      tx_irq         <= 1'b0;
      rx_irq         <= 1'b0;
    end else begin
      serial_out_pin <= uart_on ? pin_level : 1'b1;
      if (open_drain_select || CHAN == 2)
        serial_out_oe <= uart_on && !pin_level;
      else
        serial_out_oe <= uart_on;
      flow_pin_oe  <= uart_on && flow_on && flow_pin_select;
      flow_pin_out <= !(rx_allow && !rx_complete);
      tx_irq <= tx_irq_source ? tx_done : tx_start;
      rx_irq <= rx_done;
    end
  end

  // Register writes and hardware flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer          <= 9'h000;
      rx_buffer          <= 16'h0000;
      baud_divider       <= `ASU_RST_REG;
      serial_mode_reg    <= `ASU_RST_REG;
      serial_ctrl_first  <= `ASU_RST_REG;
      serial_ctrl_second <= `ASU_RST_REG;
      special_mode_one   <= `ASU_RST_REG;
      special_mode_two   <= `ASU_RST_REG;
      special_mode_three <= `ASU_RST_REG;
      special_mode_four  <= `ASU_RST_REG;
      serial_common_ctrl <= `ASU_RST_REG;
      tx_buffer_empty    <= 1'b1;
      rx_complete        <= 1'b0;
    end else begin
      if (wr_en) begin
        if (paddr == `ASU_ADDR_BAUD)
          baud_divider <= pwdata[7:0];
        else if (paddr == `ASU_ADDR_MODE)
          serial_mode_reg <= pwdata[7:0];
        else if (paddr == `ASU_ADDR_CTRL1)
          serial_ctrl_first <= pwdata[7:0];
        else if (paddr == `ASU_ADDR_CTRL2)
          serial_ctrl_second <= pwdata[7:0];
        else if (paddr == `ASU_ADDR_SMR1)
          special_mode_one <= pwdata[7:0];
        else if (paddr == `ASU_ADDR_SMR2)
          special_mode_two <= pwdata[7:0];
        else if (paddr == `ASU_ADDR_SMR3)
          special_mode_three <= pwdata[7:0];
        else if (paddr == `ASU_ADDR_SMR4)
          special_mode_four <= pwdata[7:0];
        else if (paddr == `ASU_ADDR_COMMON)
          serial_common_ctrl <= pwdata[7:0];
      end
      // Write after load keeps new data pending
      if (wr_txbuf) begin
        tx_buffer       <= pwdata[8:0];
        tx_buffer_empty <= 1'b0;
      end else if (tx_start) begin
        tx_buffer_empty <= 1'b1;
      end
      if (rx_done) begin
        rx_buffer[8:0]          <= rx_word;
        rx_buffer[11:9]         <= 3'h0;
        rx_buffer[`ASU_RB_OVR]  <= new_ovr;
        rx_buffer[`ASU_RB_FRM]  <= rx_ferr;
        rx_buffer[`ASU_RB_PAR]  <= rx_perr && parity_enable;
        rx_buffer[`ASU_RB_SUM]  <= new_ovr || rx_ferr || (rx_perr && parity_enable);
        rx_complete             <= 1'b1;
      end else if (rd_rxbuf) begin
        rx_complete <= 1'b0;
      end
    end
  end

  // Read mux, answered in the access phase
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (paddr == `ASU_ADDR_TXBUF)
      next_prdata = 32'h0000_0000;
    else if (paddr == `ASU_ADDR_RXBUF) begin
      next_prdata[15:9] = rx_buffer[15:9];
      next_prdata[8:0]  = data_logic_invert ? (~rx_buffer[8:0] & len_mask) : (rx_buffer[8:0] & len_mask);
    end else if (paddr == `ASU_ADDR_BAUD)
      next_prdata = 32'h0000_0000;
    else if (paddr == `ASU_ADDR_MODE)
      next_prdata[7:0] = serial_mode_reg;
    else if (paddr == `ASU_ADDR_CTRL1) begin
      next_prdata[7:0] = serial_ctrl_first;
      next_prdata[`ASU_C1_SHIFT_REG_EMPTY] = !tx_busy;
    end else if (paddr == `ASU_ADDR_CTRL2) begin
      next_prdata[7:0] = serial_ctrl_second;
      next_prdata[`ASU_C2_TBE] = tx_buffer_empty;
      next_prdata[`ASU_C2_RXC] = rx_complete;
    end else if (paddr == `ASU_ADDR_SMR1)
      next_prdata[7:0] = special_mode_one;
    else if (paddr == `ASU_ADDR_SMR2)
      next_prdata[7:0] = special_mode_two;
    else if (paddr == `ASU_ADDR_SMR3)
      next_prdata[7:0] = special_mode_three;
    else if (paddr == `ASU_ADDR_SMR4)
      next_prdata[7:0] = special_mode_four;
    else if (paddr == `ASU_ADDR_COMMON)
      next_prdata[7:0] = serial_common_ctrl;
    else
      next_slverr = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && next_slverr;
      if (psel && !penable && !pwrite)
        prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// ==== asu_top_asserts.sv ====
// Port-level checks for the serial channel
`default_nettype none
module asu_top_asserts (
  input wire logic       pclk,           // Clock
  input wire logic       presetn,        // Reset, low
  input wire logic       psel,           // Select
  input wire logic       penable,        // Access
  input wire logic [7:0] paddr,          // Address
  input wire logic       pready,         // Ready
  input wire logic       pslverr,        // Error
  input wire logic       serial_out_pin, // Tx level
  input wire logic       serial_out_oe,  // Tx drive
  input wire logic       tx_irq,         // Tx event
  input wire logic       rx_irq          // Rx event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_READY_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_UNMAPPED: assert property (pready && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_MAPPED: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  AST_IDLE_RESET: assert property ($rose(presetn) |-> serial_out_pin && !serial_out_oe)
    else $error("tx pin not idle after reset");
  AST_BIT_HOLD: assert property (serial_out_oe && $changed(serial_out_pin) |=> $stable(serial_out_pin) [*8])
    else $error("tx bit too short");
  AST_TX_IRQ: assert property (tx_irq |=> !tx_irq [*8])
    else $error("tx event repeats too soon");
  AST_RX_IRQ: assert property (rx_irq |=> !rx_irq [*8])
    else $error("rx event repeats too soon");
  cover property (tx_irq);
  cover property (rx_irq);
  cover property (pslverr);
endmodule
bind asu_top asu_top_asserts u_asu_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// ==== asu_remote.sv ====
// Remote serial device: frame sender, frame sampler, clear-to-send
`default_nettype none
module asu_remote #(
  parameter int BIT_CYC = 32  // Clocks per bit
) (
  input  wire logic pclk,     // Clock
  input  wire logic line_in,  // Wire from channel
  output var  logic line_out, // Wire to channel
  output var  logic cts_n     // Clear to send, low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_out = 1'b1;
  initial cts_n = 1'b0;
  task set_cts(input logic v);
    cts_n <= v;
  endtask
  task send(input logic [12:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge pclk);
      line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    @(posedge pclk);
    line_out <= 1'b1;
  endtask
  task grab(input logic idle, input int nb, output logic [12:0] f);
    int k;
    f = 13'h0;
    k = 0;
    while (line_in === idle && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      f[i] = line_in;
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ==== asu_top_bench.sv ====
// Self-checking bench for the serial channel
`include "asu_defs.vh"
`default_nettype none
module asu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, rxd, txd, txoe, cts_n, rts, rts_oe, tx_irq, rx_irq;
  logic [12:0] got;
  int          bad_count = 0, num_checks = 0;
  logic        ext_clk = 0, alt_cts = 0;
  int          tx_events = 0, rx_events = 0;
  always #10 pclk = ~pclk;
  // Free-running external count source
  always @(posedge pclk) begin
    ext_clk <= ~ext_clk;
  end
  // Event pulses counted
  always @(posedge pclk) begin
    if (tx_irq === 1'b1)
      tx_events <= tx_events + 1;
    if (rx_irq === 1'b1)
      rx_events <= rx_events + 1;
  end
  asu_top u_asu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(rxd),
    .serial_out_pin(txd), .serial_out_oe(txoe), .ext_clock_pin(ext_clk), .flow_pin_in(cts_n),
    .flow_pin_out(rts), .flow_pin_oe(rts_oe), .cts_alt_pin(alt_cts), .tx_irq(tx_irq), .rx_irq(rx_irq));
  asu_remote #(.BIT_CYC(BIT)) u_asu_remote (.pclk(pclk), .line_in(txoe ? txd : 1'b1), .line_out(rxd),
    .cts_n(cts_n));
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tx_case(input logic [7:0] md, c1, c2, input logic [8:0] d, input int nb, input logic [12:0] e);
    apb(1, `ASU_ADDR_CTRL1, {24'h0, c1});
    apb(1, `ASU_ADDR_CTRL2, {24'h0, c2});
    apb(1, `ASU_ADDR_MODE, {24'h0, md});
    repeat (10) @(posedge pclk);
    apb(1, `ASU_ADDR_TXBUF, {23'h0, d});
    u_asu_remote.grab(~md[7], nb, got);
    chk({19'h0, got}, {19'h0, e});
    repeat (2 * BIT) @(posedge pclk);
  endtask
  task t_regs;
    apb(0, `ASU_ADDR_CTRL1, 32'h0);
    chk(rd, 32'h08);
    apb(0, `ASU_ADDR_CTRL2, 32'h0);
    chk(rd, 32'h02);
    apb(1, `ASU_ADDR_MODE, 32'h25);
    apb(0, `ASU_ADDR_MODE, 32'h0);
    chk(rd, 32'h25);
    apb(1, `ASU_ADDR_BAUD, 32'h01);
    apb(0, `ASU_ADDR_BAUD, 32'h0);
    chk(rd, 32'h0);
    apb(0, 8'h2C, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task t_formats;
    tx_case(8'h64, 8'h00, 8'h01, 9'h080, 10, 13'h300);
    tx_case(8'h75, 8'h00, 8'h01, 9'h0A5, 12, 13'hF4A);
    tx_case(8'h46, 8'h00, 8'h01, 9'h1A4, 12, 13'hB48);
    tx_case(8'h05, 8'h80, 8'h01, 9'h003, 10, 13'h380);
    tx_case(8'h05, 8'h00, 8'h41, 9'h00F, 10, 13'h3E0);
    tx_case(8'h85, 8'h00, 8'h01, 9'h0A5, 10, 13'h0B5);
    apb(1, `ASU_ADDR_BAUD, 32'h00);
    tx_case(8'h0D, 8'h00, 8'h01, 9'h0A5, 10, 13'h34A);
    apb(1, `ASU_ADDR_BAUD, 32'h01);
    chk(tx_events, 32'h7);
  endtask
  task t_rx;
    apb(1, `ASU_ADDR_MODE, 32'h05);
    apb(1, `ASU_ADDR_CTRL2, 32'h05);
    u_asu_remote.send(13'h2B4, 10);
    u_asu_remote.send(13'h066, 10);
    repeat (BIT) @(posedge pclk);
    apb(0, `ASU_ADDR_RXBUF, 32'h0);
    chk(rd & 32'hF000, 32'hB000);
    u_asu_remote.send(13'h386, 10);
    repeat (BIT) @(posedge pclk);
    apb(0, `ASU_ADDR_RXBUF, 32'h0);
    chk(rd, 32'h0C3);
    chk(rx_events, 32'h3);
  endtask
  task t_flow;
    apb(1, `ASU_ADDR_CTRL1, 32'h00);
    u_asu_remote.set_cts(1'b1);
    apb(1, `ASU_ADDR_TXBUF, 32'h81);
    repeat (100) @(posedge pclk);
    chk({31'h0, txd}, 32'h1);
    u_asu_remote.set_cts(1'b0);
    repeat (2) @(posedge pclk);
    apb(1, `ASU_ADDR_TXBUF, 32'h00);
    u_asu_remote.grab(1'b1, 10, got);
    chk({19'h0, got}, 32'h302);
    repeat (12 * BIT) @(posedge pclk);
    apb(1, `ASU_ADDR_CTRL1, 32'h04);
    repeat (2) @(posedge pclk);
    chk({30'h0, rts_oe, rts}, 32'h2);
    apb(1, `ASU_ADDR_CTRL1, 32'h14);
    repeat (2) @(posedge pclk);
    chk({31'h0, rts_oe}, 32'h0);
    apb(1, `ASU_ADDR_COMMON, 32'h40);
    apb(1, `ASU_ADDR_CTRL1, 32'h04);
    alt_cts <= 1'b1;
    apb(1, `ASU_ADDR_TXBUF, 32'h55);
    repeat (20) @(posedge pclk);
    apb(0, `ASU_ADDR_CTRL2, 32'h0);
    chk(rd & 32'h2, 32'h0);
    alt_cts <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(0, `ASU_ADDR_CTRL2, 32'h0);
    chk(rd & 32'h2, 32'h2);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_formats();
    t_rx();
    t_flow();
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
